// *** cca_defs.svh ***
/*
 * Offsets, field positions, reset values and timing counts of the clear
 * channel assessment block. Definitions only; included by bare name.
 */
`ifndef CCA_DEFS_SVH
`define CCA_DEFS_SVH

// register offsets on the plain register port
`define CCA_ADDR_POL      8'h01
`define CCA_ADDR_CFG      8'h09
`define CCA_ADDR_EDTHR    8'h23
`define CCA_ADDR_EDCTRL   8'h40
`define CCA_ADDR_STATUS   8'h41
`define CCA_ADDR_NFLOOR   8'h42
`define CCA_ADDR_SQTHR    8'h43

// field positions
`define CCA_POL_BIT       2
`define CCA_SAMPLED_BIT   7
`define CCA_FN_MSB        6
`define CCA_FN_LSB        5
`define CCA_EDREL_BIT     0
`define CCA_SQUELCH_BIT   1
`define CCA_OFFS_MSB      7
`define CCA_OFFS_LSB      2

// reset values
`define CCA_RST_POL       8'h00
`define CCA_RST_CFG       8'h00
`define CCA_RST_EDTHR     8'h40
`define CCA_RST_EDCTRL    8'h00
`define CCA_RST_SQTHR     8'h20

// timing: times in ns, counts derived from the 50 ns clock period
`define CCA_PERIOD_NS     50
`define CCA_DWELL_NS      10000
`define CCA_EVAL_NS       8000
`define CCA_DWELL_CYC     ((`CCA_DWELL_NS) / (`CCA_PERIOD_NS))
`define CCA_EVAL_CYC      ((`CCA_EVAL_NS + `CCA_PERIOD_NS - 1) / (`CCA_PERIOD_NS))

`endif

// *** cca_pkg.sv ***
/*
 * Types of the clear channel assessment block.
 * Assumes cca_defs.svh carries all numeric constants.
 */
package cca_pkg;
    typedef enum logic [1:0] {
        CCA_FN_ED,
        CCA_FN_CS_SQ,
        CCA_FN_ED_AND,
        CCA_FN_ED_OR
    } cca_fn_t;

    typedef enum logic {
        CCA_ACQ,
        CCA_TRACK
    } cca_state_t;
endpackage

// *** cca_nf_mem.sv ***
/*
 * Noise floor sample memory: 256 level samples for each of two antennas.
 * Assumes one write and one read per cycle on the block clock; read data
 * appear one cycle after the address, from a register.
 */
`timescale 1ns/1ps
module cca_nf_mem (
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic       wr_in,
    input  wire logic [8:0] waddr_in,
    input  wire logic [7:0] wdata_in,
    input  wire logic [8:0] raddr_in,
    output logic      [7:0] rdata_out
);
    logic [7:0] mem [512];

    // array left without reset so it maps onto plain ram
    always_ff @(posedge clk_in) begin
        if (wr_in) begin
            mem[waddr_in] <= wdata_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rdata_out <= 8'h00;
        end else begin
            rdata_out <= mem[raddr_in];
        end
    end
endmodule

// *** cca_assess.sv ***
/*
 * Clear channel assessment and energy detect of the baseband receiver.
 * Assumes the gain loop, correlator and demodulator status inputs come from
 * logic on clk_in; only the receive path enable is an outside pin.
 */
// Chosen here: the register addresses and the strobed register port.
`timescale 1ns/1ps
`include "cca_defs.svh"

module cca_assess
    import cca_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic [7:0] reg_addr_in,
    input  wire logic [7:0] reg_wdata_in,
    input  wire logic       reg_wr_in,
    input  wire logic       reg_rd_in,
    output logic      [7:0] reg_rdata_out,
    input  wire logic       receive_path_enable_in,
    input  wire logic       agc_locked_in,
    input  wire logic [6:0] agc_gain_in,
    input  wire logic       pn_detect_in,
    input  wire logic [7:0] pn_ratio_in,
    input  wire logic       phase_mod_present_in,
    input  wire logic       antenna_in,
    input  wire logic       symbol_strobe_in,
    output logic            channel_busy_out,
    output logic            energy_detect_flag_out,
    output logic            tracking_out
);
    logic [7:0]  pol_r;
    logic [7:0]  cfg_r;
    logic [7:0]  ed_thr_r;
    logic [7:0]  ed_ctrl_r;
    logic [7:0]  sq_thr_r;
    logic        en_s1_r;
    logic        en_s2_r;
    logic [7:0]  dwell_cnt_r;
    logic        locked_all_r;
    logic        cs_r;
    logic        sq_r;
    logic        sq_hist_r;
    cca_state_t  state_r;
    logic        busy_smp_r;
    logic        ph_r;
    logic [7:0]  samp_lvl_r;
    logic        samp_ant_r;
    logic [7:0]  idx_r [2];
    logic [15:0] sum_r [2];
    logic [1:0]  nf_valid_r;
    logic [7:0]  old_lvl;
    logic [7:0]  level;
    logic [7:0]  nf_cur;
    logic [7:0]  thr;
    logic        eval_pt;
    logic        eval_do;
    logic        sq_eval;
    logic        busy_now;
    logic        samp_go;

    // 7-bit gain word: more gain means a weaker input, so invert it
    function automatic logic [7:0] lvl_from_gain(input logic [6:0] g);
        return {1'b0, ~g};
    endfunction

    function automatic logic [7:0] sat_add(input logic [7:0] a, input logic [5:0] b);
        logic [8:0] s;
        s = {1'b0, a} + {3'b000, b};
        return s[8] ? 8'hFF : s[7:0];
    endfunction

    // register port
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pol_r     <= `CCA_RST_POL;
            cfg_r     <= `CCA_RST_CFG;
            ed_thr_r  <= `CCA_RST_EDTHR;
            ed_ctrl_r <= `CCA_RST_EDCTRL;
            sq_thr_r  <= `CCA_RST_SQTHR;
        end else if (reg_wr_in) begin
            case (reg_addr_in)
                `CCA_ADDR_POL:    pol_r     <= reg_wdata_in;
                `CCA_ADDR_CFG:    cfg_r     <= reg_wdata_in;
                `CCA_ADDR_EDTHR:  ed_thr_r  <= reg_wdata_in;
                `CCA_ADDR_EDCTRL: ed_ctrl_r <= reg_wdata_in;
                `CCA_ADDR_SQTHR:  sq_thr_r  <= reg_wdata_in;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            reg_rdata_out <= 8'h00;
        end else if (reg_rd_in) begin
            case (reg_addr_in)
                `CCA_ADDR_POL:    reg_rdata_out <= pol_r;
                `CCA_ADDR_CFG:    reg_rdata_out <= cfg_r;
                `CCA_ADDR_EDTHR:  reg_rdata_out <= ed_thr_r;
                `CCA_ADDR_EDCTRL: reg_rdata_out <= ed_ctrl_r;
                `CCA_ADDR_SQTHR:  reg_rdata_out <= sq_thr_r;
                `CCA_ADDR_STATUS: reg_rdata_out <= {2'b00, nf_valid_r, tracking_out,
                                                    energy_detect_flag_out, sq_r, cs_r};
                `CCA_ADDR_NFLOOR: reg_rdata_out <= nf_cur;
                default:          reg_rdata_out <= 8'h00;
            endcase
        end else begin
            reg_rdata_out <= 8'h00;
        end
    end

    // receive enable is a pin from the controller
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            en_s1_r <= 1'b0;
            en_s2_r <= 1'b0;
        end else begin
            en_s1_r <= receive_path_enable_in;
            en_s2_r <= en_s1_r;
        end
    end

    // dwell timing; the count restarts with each rise of the enable
    assign eval_pt = en_s2_r && (dwell_cnt_r == 8'(`CCA_EVAL_CYC));
    assign eval_do = eval_pt && locked_all_r && agc_locked_in;

    always_ff @(posedge clk_in) begin
        if (rst_in || !en_s2_r || dwell_cnt_r == 8'(`CCA_DWELL_CYC - 1)) begin
            dwell_cnt_r  <= 8'h00;
            locked_all_r <= 1'b1;
        end else begin
            dwell_cnt_r  <= dwell_cnt_r + 8'h01;
            locked_all_r <= locked_all_r && agc_locked_in;
        end
    end

    // quality needs the code detect, the ratio, and optionally the energy squelch
    assign sq_eval = pn_detect_in && (pn_ratio_in > sq_thr_r)
                     && !(ed_ctrl_r[`CCA_SQUELCH_BIT] && !energy_detect_flag_out);

    always_ff @(posedge clk_in) begin
        if (rst_in || !en_s2_r) begin
            sq_r      <= 1'b0;
            sq_hist_r <= 1'b0;
        end else if (eval_do) begin
            sq_r      <= sq_eval;
            sq_hist_r <= sq_eval;
        end else if (eval_pt) begin
            // a skipped evaluation breaks the consecutive pair
            sq_hist_r <= 1'b0;
        end
    end

    // unlock and evaluation cannot coincide, since evaluation needs lock
    always_ff @(posedge clk_in) begin
        if (rst_in || !en_s2_r) begin
            cs_r <= 1'b0;
        end else if (!agc_locked_in) begin
            cs_r <= 1'b1;
        end else if (eval_do) begin
            cs_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in || !en_s2_r) begin
            state_r      <= CCA_ACQ;
            tracking_out <= 1'b0;
        end else begin
            case (state_r)
                CCA_ACQ: begin
                    if (eval_do && sq_eval && (cs_r || sq_hist_r)) begin
                        state_r      <= CCA_TRACK;
                        tracking_out <= 1'b1;
                    end
                end
                CCA_TRACK: begin
                    state_r      <= CCA_TRACK;
                    tracking_out <= 1'b1;
                end
                default: begin
                    state_r      <= CCA_ACQ;
                    tracking_out <= 1'b0;
                end
            endcase
        end
    end

    // energy detect
    assign level  = lvl_from_gain(agc_gain_in);
    assign nf_cur = sum_r[antenna_in][15:8];
    assign thr    = (ed_ctrl_r[`CCA_EDREL_BIT] && nf_valid_r[antenna_in])
                    ? sat_add(nf_cur, ed_ctrl_r[`CCA_OFFS_MSB:`CCA_OFFS_LSB])
                    : ed_thr_r;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            energy_detect_flag_out <= 1'b0;
        end else begin
            energy_detect_flag_out <= en_s2_r && (level > thr);
        end
    end

    // noise floor: two-cycle read-modify-write keeps a running sum per antenna;
    // 256 samples at one per two cycles fill in 25.6 us
    assign samp_go = en_s2_r && !phase_mod_present_in && !ph_r;

    cca_nf_mem u_mem (
        .clk_in    (clk_in),
        .rst_in    (rst_in),
        .wr_in     (ph_r),
        .waddr_in  ({samp_ant_r, idx_r[samp_ant_r]}),
        .wdata_in  (samp_lvl_r),
        .raddr_in  ({antenna_in, idx_r[antenna_in]}),
        .rdata_out (old_lvl)
    );

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ph_r       <= 1'b0;
            samp_lvl_r <= 8'h00;
            samp_ant_r <= 1'b0;
        end else begin
            ph_r <= samp_go;
            if (samp_go) begin
                samp_lvl_r <= level;
                samp_ant_r <= antenna_in;
            end
        end
    end

    // only reset clears the floors; the receive enable does not
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            idx_r[0]   <= 8'h00;
            idx_r[1]   <= 8'h00;
            sum_r[0]   <= 16'h0000;
            sum_r[1]   <= 16'h0000;
            nf_valid_r <= 2'b00;
        end else if (ph_r) begin
            idx_r[samp_ant_r] <= idx_r[samp_ant_r] + 8'h01;
            sum_r[samp_ant_r] <= sum_r[samp_ant_r] + {8'h00, samp_lvl_r}
                                 - (nf_valid_r[samp_ant_r] ? {8'h00, old_lvl} : 16'h0000);
            if (idx_r[samp_ant_r] == 8'hFF) begin
                nf_valid_r[samp_ant_r] <= 1'b1;
            end
        end
    end

    // busy function
    always_comb begin
        case (cca_fn_t'(cfg_r[`CCA_FN_MSB:`CCA_FN_LSB]))
            CCA_FN_ED:     busy_now = energy_detect_flag_out;
            CCA_FN_CS_SQ:  busy_now = cs_r || sq_r || tracking_out;
            CCA_FN_ED_AND: busy_now = energy_detect_flag_out && (cs_r || sq_r || tracking_out);
            CCA_FN_ED_OR:  busy_now = energy_detect_flag_out || cs_r || sq_r || tracking_out;
            default:       busy_now = 1'b0;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (rst_in || !en_s2_r) begin
            busy_smp_r <= 1'b0;
        end else if (symbol_strobe_in) begin
            busy_smp_r <= busy_now;
        end
    end

    // unsampled path follows every change of its inputs
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            channel_busy_out <= 1'b0;
        end else begin
            channel_busy_out <= (en_s2_r && (cfg_r[`CCA_SAMPLED_BIT] ? busy_smp_r : busy_now))
                                ^ pol_r[`CCA_POL_BIT];
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    sequence s_disabled2;
        !en_s2_r ##1 !en_s2_r;
    endsequence

    a_unlock_sets: assert property (en_s2_r && !agc_locked_in |=> cs_r)
        else $error("unlock sense not set after unlock");
    a_false_clears: assert property (eval_do && !sq_eval |=> !cs_r && !sq_r)
        else $error("false evaluation did not clear unlock sense");
    a_unlock_track: assert property (state_r == CCA_ACQ && eval_do && sq_eval && cs_r
                                     ##1 en_s2_r |-> tracking_out)
        else $error("no tracking after unlock and true quality");
    a_quality_cause: assert property ($rose(sq_r) |-> $past(pn_detect_in && pn_ratio_in > sq_thr_r))
        else $error("quality rose without correlation cause");
    a_quality_time: assert property ($rose(sq_r) |-> $past(dwell_cnt_r) == 8'(`CCA_EVAL_CYC))
        else $error("quality updated off the evaluation point");
    a_single_nottrack: assert property (state_r == CCA_ACQ && !cs_r && !sq_hist_r |=> !tracking_out)
        else $error("tracking entered after a single evaluation");
    a_floor_kept: assert property ($fell(en_s2_r) |=> ##1 nf_valid_r == $past(nf_valid_r)
                                   && sum_r[0] == $past(sum_r[0]) && sum_r[1] == $past(sum_r[1]))
        else $error("noise floor lost on enable drop");
    a_idle_polarity: assert property (s_disabled2 |-> channel_busy_out == $past(pol_r[`CCA_POL_BIT]))
        else $error("idle busy level ignores polarity");
    a_sampled_hold: assert property ($changed(channel_busy_out) && $past(cfg_r[`CCA_SAMPLED_BIT])
                                     && $past(cfg_r[`CCA_SAMPLED_BIT], 2) && $past(pol_r) == $past(pol_r, 2)
                                     && $past(en_s2_r) && $past(en_s2_r, 2) |-> $past(symbol_strobe_in, 2))
        else $error("sampled busy changed without symbol strobe");
endmodule

// *** cca_mac_model.sv ***
/*
 * Behavioural medium access controller on the far side of the busy output.
 * Assumes the bench drives its enable and data valid inputs on clk_in and
 * hands it the programmed busy polarity.
 */
`timescale 1ns/1ps
module cca_mac_model (
    input  wire logic clk_in,
    input  wire logic rst_in,
    input  wire logic rx_en_in,
    input  wire logic busy_in,
    input  wire logic pol_in,
    input  wire logic data_valid_in,
    output logic      clear_out
);
    logic [3:0] settle_r;
    logic       frozen_r;
    // busy is meaningless right after enable rises and while it is low
    always_ff @(posedge clk_in) begin
        if (rst_in || !rx_en_in) begin
            settle_r <= 4'h0;
        end else if (settle_r != 4'hF) begin
            settle_r <= settle_r + 4'h1;
        end
    end
    // once data are valid the rest of the message ignores busy
    always_ff @(posedge clk_in) begin
        if (rst_in || !rx_en_in) begin
            frozen_r <= 1'b0;
        end else if (data_valid_in) begin
            frozen_r <= 1'b1;
        end
    end
    // clear when the pin shows its idle level; a send may ignore this
    assign clear_out = rx_en_in && (settle_r == 4'hF) && !frozen_r && (busy_in == pol_in);
endmodule

// *** test_clear_channel_assessment.sv ***
/*
 * Self-checking bench of the assessment block with register tasks.
 * Assumes the block and the controller model share the 20 MHz clock.
 */
`timescale 1ns/1ps
module test_clear_channel_assessment;
    import cca_pkg::*;
    logic       clk_in = 0, rst_in = 1;
    logic [7:0] a = 8'h00, wd = 8'h00, rdat;
    logic       wr = 0, rd = 0, en = 0, lk = 1, pn = 0, pm = 1, sym = 0, dv = 0, pol = 0;
    logic [6:0] gn = 7'h7F;
    logic [7:0] rt = 8'h00;
    logic       busy, ed, trk, clr;
    int         miscompares = 0, cmp_count = 0;
    always #25 clk_in = ~clk_in;
    cca_assess dut (.clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(a), .reg_wdata_in(wd),
        .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdat), .receive_path_enable_in(en),
        .agc_locked_in(lk), .agc_gain_in(gn), .pn_detect_in(pn), .pn_ratio_in(rt),
        .phase_mod_present_in(pm), .antenna_in(1'b0), .symbol_strobe_in(sym),
        .channel_busy_out(busy), .energy_detect_flag_out(ed), .tracking_out(trk));
    cca_mac_model mac (.clk_in(clk_in), .rst_in(rst_in), .rx_en_in(en), .busy_in(busy),
        .pol_in(pol), .data_valid_in(dv), .clear_out(clr));
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string m);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp, input string m);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %0t: %s got %b expected %b", $time, m, got, exp);
        end
    endtask
    task automatic wreg(input logic [7:0] ad, input logic [7:0] dt);
        @(posedge clk_in);
        a  <= ad;
        wd <= dt;
        wr <= 1'b1;
        @(posedge clk_in);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [7:0] ad, input logic [7:0] exp);
        @(posedge clk_in);
        a  <= ad;
        rd <= 1'b1;
        @(posedge clk_in);
        rd <= 1'b0;
        #1 chk8(rdat, exp, "register read");
    endtask
    function automatic logic pick(input int s);
        return (s == 0) ? busy : trk;
    endfunction
    // bounded wait on busy (0) or tracking (1), then one compare
    task automatic wt(input int s, input logic v, input int n);
        for (int i = 0; i < n && pick(s) !== v; i++) @(posedge clk_in);
        if (pick(s) !== v) begin
            miscompares++;
            $display("Error %0t: wait for level %b ran out", $time, v);
            summarize();
        end else begin
            chk1(pick(s), v, "awaited level");
        end
    endtask
    task automatic pulse_sym();
        @(posedge clk_in);
        sym <= 1'b1;
        @(posedge clk_in);
        sym <= 1'b0;
    endtask
    task automatic rx_restart();
        @(posedge clk_in);
        en <= 1'b0;
        cyc(6);
        en <= 1'b1;
        cyc(4);
    endtask
    task automatic unlock_blip();
        @(posedge clk_in);
        lk <= 1'b0;
        cyc(2);
        lk <= 1'b1;
    endtask
    logic [7:0] rst_tab [5] = '{8'h00, 8'h00, 8'h40, 8'h00, 8'h20};
    logic [7:0] adr_tab [5] = '{8'h01, 8'h09, 8'h23, 8'h40, 8'h43};
    initial begin
        cyc(12);
        rst_in <= 1'b0;
        for (int i = 0; i < 5; i++) rreg(adr_tab[i], rst_tab[i]);
        rreg(8'h10, 8'h00);
        wreg(8'h43, 8'hA5);
        rreg(8'h43, 8'hA5);
        wreg(8'h41, 8'hFF);
        rreg(8'h41, 8'h00);
        wreg(8'h43, 8'h20);
        $display("test registers done");
        // learn a floor of 0x20 on antenna 0, then use 8 dB above it
        en <= 1'b1;
        pm <= 1'b0;
        gn <= 7'h5F;
        cyc(700);
        pm <= 1'b1;
        rreg(8'h42, 8'h20);
        rreg(8'h41, 8'h10);
        wreg(8'h40, 8'h21);
        gn <= 7'h53;
        cyc(4);
        chk1(ed, 1'b1, "level above floor plus offset");
        gn <= 7'h5B;
        cyc(4);
        chk1(ed, 1'b0, "level below floor plus offset");
        rx_restart();
        rreg(8'h42, 8'h20);
        wreg(8'h40, 8'h00);
        $display("test noise floor done");
        gn <= 7'h00;
        cyc(4);
        chk1(ed, 1'b1, "absolute threshold passed");
        chk1(busy, 1'b1, "energy only busy");
        cyc(20);
        chk1(clr, 1'b0, "controller sees busy");
        wreg(8'h01, 8'h04);
        pol <= 1'b1;
        cyc(3);
        chk1(busy, 1'b0, "active low busy");
        wreg(8'h01, 8'h00);
        pol <= 1'b0;
        gn <= 7'h7F;
        cyc(4);
        chk1(busy, 1'b0, "energy gone");
        wreg(8'h09, 8'h40);
        gn <= 7'h00;
        cyc(4);
        chk1(busy, 1'b0, "and function without unlock");
        wreg(8'h09, 8'h60);
        gn <= 7'h7F;
        cyc(4);
        chk1(busy, 1'b0, "or function idle");
        unlock_blip();
        cyc(4);
        chk1(busy, 1'b1, "or function after unlock");
        $display("test energy and polarity done");
        wreg(8'h09, 8'h20);
        rx_restart();
        unlock_blip();
        cyc(4);
        chk1(busy, 1'b1, "unlock sense busy");
        wt(0, 1'b0, 500);
        chk1(trk, 1'b0, "false evaluation no tracking");
        pn <= 1'b1;
        rt <= 8'h30;
        unlock_blip();
        wt(1, 1'b1, 500);
        chk1(busy, 1'b1, "tracking stays busy");
        rt <= 8'h20;
        rx_restart();
        cyc(450);
        chk1(trk, 1'b0, "ratio at threshold refused");
        rt <= 8'h30;
        rx_restart();
        cyc(280);
        chk1(trk, 1'b0, "one evaluation is not enough");
        wt(1, 1'b1, 200);
        $display("test acquisition done");
        wreg(8'h09, 8'h80);
        pulse_sym();
        cyc(3);
        chk1(busy, 1'b0, "sampled idle");
        gn <= 7'h00;
        cyc(6);
        chk1(busy, 1'b0, "no update between symbols");
        pulse_sym();
        cyc(3);
        chk1(busy, 1'b1, "update on symbol");
        gn <= 7'h7F;
        pulse_sym();
        cyc(3);
        chk1(clr, 1'b1, "controller sees clear");
        dv <= 1'b1;
        cyc(2);
        chk1(clr, 1'b0, "busy ignored after data valid");
        $display("test sampled mode done");
        summarize();
    end
endmodule
